//--- pkg/cpmc_pkg.sv
// shared constants and types for the cpu power mode control block
package cpmc_pkg;
    // ==========================================================
    // register map
    localparam logic [7:0] CPMC_PCTL_ADDR    = 8'h87;
    localparam logic [7:0] CPMC_PCTL_RESET   = 8'h00;
    localparam int         CPMC_IDLE_BIT     = 0;
    localparam int         CPMC_STOP_BIT     = 1;
    localparam int         CPMC_RSVD2_BIT    = 2;
    localparam int         CPMC_SST1_BIT     = 3;
    localparam int         CPMC_SBH1_BIT     = 4;
    localparam int         CPMC_RSVD5_BIT    = 5;
    localparam int         CPMC_SST0_BIT     = 6;
    localparam int         CPMC_SBH0_BIT     = 7;
    // reserved bits 5 and 2 and the one-shot bits 1 and 0 read as zero
    localparam logic [7:0] CPMC_KEEP_MASK    = 8'hD8;
    // fetch address after any reset that ends idle or stop
    localparam logic [15:0] CPMC_RESET_VECTOR = 16'h0000;

    // ==========================================================
    // timing
    localparam int CPMC_CLK_MHZ      = 50;
    localparam int CPMC_DET_TIME_US  = 100;
    localparam int CPMC_DET_CYCLES   = CPMC_DET_TIME_US * CPMC_CLK_MHZ;
    localparam int CPMC_CNT_W        = 16;

    // ==========================================================
    // power states, one-hot
    typedef enum logic [2:0] {
        CPMC_RUN  = 3'h1,
        CPMC_IDLE = 3'h2,
        CPMC_STOP = 3'h4
    } cpmc_state_e;
endpackage : cpmc_pkg

//--- pkg/cpmc_if.sv
// carrier between the mode controller and the missing clock timer
`timescale 1ns/10ps
interface cpmc_if;
    logic clock_halted;   // oscillator gated off
    logic detector_on;    // detector enabled
    logic timeout;        // detector expired, one cycle
    modport ctrl  (output clock_halted, output detector_on, input timeout);
    modport timer (input clock_halted, input detector_on, output timeout);
endinterface : cpmc_if

//--- hw/cpmc_mcd_timer.sv
// missing clock timer: counts a free running reference while the clock is halted
`timescale 1ns/10ps
module cpmc_det_timer
    import cpmc_pkg::*;
#(
    parameter int DET_CYCLES = CPMC_DET_CYCLES
) (
    input  wire logic  CORE_CLK,
    input  wire logic  RST,
    cpmc_if.timer      link
);
    typedef struct packed {
        logic [CPMC_CNT_W-1:0] count;
        logic                  fired;
    } cpmc_tmr_s;

    cpmc_tmr_s cur;
    cpmc_tmr_s next_cur;

    // ==========================================================
    // timeout counter; modelled on the free reference, not the halted clock
    always_comb begin
        next_cur = cur;
        next_cur.fired = 1'b0;
        if (!(link.clock_halted && link.detector_on)) begin
            next_cur.count = '0;
        end else if (cur.count == CPMC_CNT_W'(DET_CYCLES - 1)) begin
            next_cur.fired = 1'b1;
            next_cur.count = '0;
        end else begin
            next_cur.count = cur.count + CPMC_CNT_W'(1);
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign link.timeout = cur.fired;
endmodule : cpmc_det_timer

//--- hw/cpmc_top.sv
// cpu power mode control: power control register, idle and stop sequencing
// How it works
// - writing stop bit enters stop once the writing instruction completes
// - stop halts cpu clock and oscillator, stopping digital peripherals
// - only internal or external reset leaves stop; interrupts ignored
// - reset ending stop runs normal sequence, fetch restarts at zero
// - enabled missing clock detector resets after 100 us of halted clock
// - idle bit halts cpu after instruction; peripherals keep clocks
// - enabled interrupt in idle clears idle and resumes the cpu
// - reset during idle ends idle, restarting at address zero
`timescale 1ns/10ps
module cpmc_top
    import cpmc_pkg::*;
(
    input  wire logic       CORE_CLK,
    input  wire logic       RST,
    input  wire logic [7:0] SFR_ADDR,
    input  wire logic [7:0] SFR_WDATA,
    input  wire logic       SFR_WR,
    input  wire logic       SFR_RD,
    output logic      [7:0] SFR_RDATA,
    input  wire logic       INSN_DONE,
    input  wire logic       IRQ_PENDING,
    input  wire logic       DETECTOR_ENABLE,
    output logic            CPU_CLK_EN,
    output logic            OSC_EN,
    output logic            IDLE_ACTIVE,
    output logic            STOP_ACTIVE,
    output logic            INTERNAL_RESET,
    output logic [15:0]     RESET_VECTOR,
    output logic            SERIAL0_BAUD_HALVING_OFF,
    output logic            SERIAL0_ENHANCED_STATUS_VIEW,
    output logic            SERIAL1_BAUD_HALVING_OFF,
    output logic            SERIAL1_ENHANCED_STATUS_VIEW
);
    // all block state lives in one packed struct so reset can clear it in
    // one place; the detector timeout resets only state, stop_req, idle_req and kept; the two filtered
    // inputs cost four flops each, traded for immunity to glitches
    // on the interrupt and detector enable lines, which come from
    // outside this clock's reach
    typedef struct packed {
        cpmc_state_e state;
        logic [7:0]  kept;        // serial bits held in the register
        logic        stop_req;    // stop write seen, waiting for insn end
        logic        idle_req;    // idle write seen, waiting for insn end
        logic [7:0]  rdata;
        logic        irq_s1;
        logic        irq_s2;
        logic        irq_s3;
        logic        det_s1;
        logic        det_s2;
        logic        det_s3;
        logic        irq_q;       // filtered interrupt level
        logic        det_q;       // filtered detector enable
        logic        int_rst;
    } cpmc_top_s;

    cpmc_top_s cur;
    cpmc_top_s next_cur;
    cpmc_if    link ();

    // ==========================================================
    // missing clock timer; runs while the core clock is gated off
    // limitation: a long stop with the detector left on always ends early
    cpmc_det_timer #(
        .DET_CYCLES (CPMC_DET_CYCLES)
    ) cpmc_det_timer_inst (
        .CORE_CLK (CORE_CLK),
        .RST      (RST),
        .link     (link)
    );

    assign link.clock_halted = (cur.state == CPMC_STOP);
    assign link.detector_on  = cur.det_q;

    // ==========================================================
    // next state
    always_comb begin
        logic wr_hit;
        logic rd_hit;
        wr_hit = 1'b0;
        rd_hit = 1'b0;
        next_cur = cur;
        wr_hit = SFR_WR && (SFR_ADDR == CPMC_PCTL_ADDR);
        rd_hit = SFR_RD && (SFR_ADDR == CPMC_PCTL_ADDR);

        // pin-style inputs: three stages, accept when last two agree
        next_cur.irq_s1 = IRQ_PENDING;
        next_cur.irq_s2 = cur.irq_s1;
        next_cur.irq_s3 = cur.irq_s2;
        if (cur.irq_s2 == cur.irq_s3) begin
            next_cur.irq_q = cur.irq_s3;
        end
        next_cur.det_s1 = DETECTOR_ENABLE;
        next_cur.det_s2 = cur.det_s1;
        next_cur.det_s3 = cur.det_s2;
        if (cur.det_s2 == cur.det_s3) begin
            next_cur.det_q = cur.det_s3;
        end

        // register write: serial bits stored, mode bits latched as one-shots
        if (wr_hit && cur.state == CPMC_RUN) begin
            next_cur.kept = SFR_WDATA & CPMC_KEEP_MASK;
            if (SFR_WDATA[CPMC_STOP_BIT]) begin
                next_cur.stop_req = 1'b1;
            end
            if (SFR_WDATA[CPMC_IDLE_BIT]) begin
                next_cur.idle_req = 1'b1;
            end
        end

        // read returns kept bits; mode bits and reserved bits always zero
        if (rd_hit) begin
            next_cur.rdata = cur.kept;
        end else begin
            next_cur.rdata = 8'h00;
        end

        next_cur.int_rst = link.timeout;

        case (cur.state)
            CPMC_RUN: begin
                // stop wins when both bits are written together
                if (INSN_DONE && (cur.stop_req || (wr_hit && SFR_WDATA[CPMC_STOP_BIT]))) begin
                    next_cur.state    = CPMC_STOP;
                    next_cur.stop_req = 1'b0;
                    next_cur.idle_req = 1'b0;
                end else if (INSN_DONE
                             && (cur.idle_req || (wr_hit && SFR_WDATA[CPMC_IDLE_BIT]))) begin
                    next_cur.state    = CPMC_IDLE;
                    next_cur.idle_req = 1'b0;
                end
            end
            CPMC_IDLE: begin
                // resume only on the filtered level, never on a glitch
                if (cur.irq_q) begin
                    next_cur.state = CPMC_RUN;
                end
            end
            CPMC_STOP: begin
                // interrupts deliberately not looked at here
                next_cur.state = CPMC_STOP;
            end
            default: begin
                next_cur.state = CPMC_RUN;
            end
        endcase

        // detector reset clears state, both requests and kept; the filters and rdata run on
        if (link.timeout) begin
            next_cur.state    = CPMC_RUN;
            next_cur.stop_req = 1'b0;
            next_cur.idle_req = 1'b0;
            next_cur.kept     = CPMC_PCTL_RESET;
        end
    end

    // ==========================================================
    // state register; RST ends idle or stop
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            cur       <= '0;
            cur.state <= CPMC_RUN;
            cur.kept  <= CPMC_PCTL_RESET;
        end else begin
            cur <= next_cur;
        end
    end

    // ==========================================================
    // outputs
    assign CPU_CLK_EN   = (cur.state == CPMC_RUN);
    assign OSC_EN       = (cur.state != CPMC_STOP);
    assign IDLE_ACTIVE  = (cur.state == CPMC_IDLE);
    assign STOP_ACTIVE  = (cur.state == CPMC_STOP);
    assign INTERNAL_RESET = cur.int_rst;
    assign RESET_VECTOR = CPMC_RESET_VECTOR;
    assign SFR_RDATA    = cur.rdata;
    assign SERIAL0_BAUD_HALVING_OFF     = cur.kept[CPMC_SBH0_BIT];
    assign SERIAL0_ENHANCED_STATUS_VIEW = cur.kept[CPMC_SST0_BIT];
    assign SERIAL1_BAUD_HALVING_OFF     = cur.kept[CPMC_SBH1_BIT];
    assign SERIAL1_ENHANCED_STATUS_VIEW = cur.kept[CPMC_SST1_BIT];
endmodule : cpmc_top

//--- bench/cpmc_properties.sv
// concurrent checks on the power mode controller ports
`timescale 1ns/10ps
module cpmc_properties
    import cpmc_pkg::*;
(
    input wire logic       CORE_CLK,
    input wire logic       RST,
    input wire logic [7:0] SFR_ADDR,
    input wire logic [7:0] SFR_WDATA,
    input wire logic       SFR_WR,
    input wire logic       SFR_RD,
    input wire logic [7:0] SFR_RDATA,
    input wire logic       INSN_DONE,
    input wire logic       IRQ_PENDING,
    input wire logic       CPU_CLK_EN,
    input wire logic       OSC_EN,
    input wire logic       IDLE_ACTIVE,
    input wire logic       STOP_ACTIVE,
    input wire logic       INTERNAL_RESET
);
    // ==========================================================
    // properties
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    // a write only counts in run; go also needs the end of an instruction
    wire go = SFR_WR && SFR_ADDR == CPMC_PCTL_ADDR && CPU_CLK_EN && INSN_DONE;
    // six quiet cycles so the irq filter cannot wake idle at once
    sequence s_quiet; !IRQ_PENDING [*6]; endsequence
    sequence s_idle; go && SFR_WDATA[1:0] == 2'h1; endsequence
    property p_stop_in; go && SFR_WDATA[1] |=> STOP_ACTIVE; endproperty
    property p_stop_off; STOP_ACTIVE |-> !OSC_EN && !CPU_CLK_EN; endproperty
    property p_stop_hold; STOP_ACTIVE |=> STOP_ACTIVE || INTERNAL_RESET; endproperty
    property p_det; INTERNAL_RESET |-> $past(STOP_ACTIVE) && CPU_CLK_EN; endproperty
    property p_idle_in; s_quiet ##0 s_idle |=> IDLE_ACTIVE; endproperty
    property p_idle_off; IDLE_ACTIVE |-> !CPU_CLK_EN && OSC_EN; endproperty
    property p_wake; IRQ_PENDING [*8] |-> !IDLE_ACTIVE; endproperty
    property p_rd; SFR_RD |=> SFR_RDATA[2:0] == 3'h0 && !SFR_RDATA[5]; endproperty
    a_stop_in: assert property (p_stop_in) else $error("no stop");
    a_stop_off: assert property (p_stop_off) else $error("clock on");
    a_stop_hold: assert property (p_stop_hold) else $error("left stop");
    a_det: assert property (p_det) else $error("bad timeout");
    a_idle_in: assert property (p_idle_in) else $error("no idle");
    a_idle_off: assert property (p_idle_off) else $error("idle clocks");
    a_wake: assert property (p_wake) else $error("no wake");
    a_rd: assert property (p_rd) else $error("bits read");
endmodule : cpmc_properties

bind cpmc_top cpmc_properties cpmc_properties_inst (.CORE_CLK, .RST, .SFR_ADDR, .SFR_WDATA,
    .SFR_WR, .SFR_RD, .SFR_RDATA, .INSN_DONE, .IRQ_PENDING, .CPU_CLK_EN, .OSC_EN,
    .IDLE_ACTIVE, .STOP_ACTIVE, .INTERNAL_RESET);

//--- bench/test_cpmc_top.sv
// self-checking bench for the power mode controller
`timescale 1ns/10ps
module test_cpmc_top
    import cpmc_pkg::*;
;
    logic        CORE_CLK = 1'b0;
    logic        RST = 1'b1;
    logic [7:0]  SFR_ADDR = 8'h00;
    logic [7:0]  SFR_WDATA = 8'h00;
    logic        SFR_WR = 1'b0;
    logic        SFR_RD = 1'b0;
    logic        INSN_DONE = 1'b0;
    logic        IRQ_PENDING = 1'b0;
    logic        DETECTOR_ENABLE = 1'b0;
    logic [7:0]  SFR_RDATA;
    logic        INTERNAL_RESET;
    logic [15:0] RESET_VECTOR;
    logic [3:0]  md;
    logic [3:0]  ser;
    logic [31:0] seed = 32'hA0AAD3B9;
    logic [7:0]  last;
    logic [7:0]  v;
    int          n;
    int          n_fail = 0;
    int          n_checks = 0;

    cpmc_top cpmc_top_inst (.CORE_CLK, .RST, .SFR_ADDR, .SFR_WDATA, .SFR_WR, .SFR_RD,
        .SFR_RDATA, .INSN_DONE, .IRQ_PENDING, .DETECTOR_ENABLE, .CPU_CLK_EN(md[3]),
        .OSC_EN(md[2]), .IDLE_ACTIVE(md[1]), .STOP_ACTIVE(md[0]), .INTERNAL_RESET,
        .RESET_VECTOR, .SERIAL0_BAUD_HALVING_OFF(ser[3]),
        .SERIAL0_ENHANCED_STATUS_VIEW(ser[2]), .SERIAL1_BAUD_HALVING_OFF(ser[1]),
        .SERIAL1_ENHANCED_STATUS_VIEW(ser[0]));

    // ==========================================================
    // clock and helpers; mode nibble is run C, idle 6, stop 1
    initial forever #10 CORE_CLK = ~CORE_CLK;
    task automatic tick(input int c);
        repeat (c) @(posedge CORE_CLK);
        #1;
    endtask : tick
    task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    // one-shot and reserved bits never read back
    function automatic logic [11:0] exp_rd(input logic [7:0] d);
        return {d & 8'hD8, d[7], d[6], d[4], d[3]};
    endfunction : exp_rd
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic i);
        {SFR_ADDR, SFR_WDATA, SFR_WR, INSN_DONE} = {a, d, 1'b1, i};
        tick(1);
        {SFR_WR, INSN_DONE} = 2'b00;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        {SFR_ADDR, SFR_RD} = {a, 1'b1};
        tick(1);
        SFR_RD = 1'b0;
        v = SFR_RDATA;
    endtask : rd
    task automatic test_done;
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : test_done

    // ==========================================================
    // scenarios
    initial begin
        tick(16);
        RST = 1'b0;
        rd(CPMC_PCTL_ADDR);
        chk({v, md}, 12'h00C);
        repeat (12) begin
            seed = xs(seed);
            last = seed[7:0] & 8'hFC;
            wr(CPMC_PCTL_ADDR, last, seed[8]);
            rd(CPMC_PCTL_ADDR);
            chk({v, ser}, exp_rd(seed[7:0]));
            wr(seed[15:8] & 8'hFE, 8'h03, 1'b1);
            rd(seed[15:8] & 8'hFE);
            chk({v, md}, 12'h00C);
        end
        // idle only lands at the end of the writing instruction
        wr(CPMC_PCTL_ADDR, last | 8'h01, 1'b0);
        tick(2);
        chk(md, 4'hC);
        INSN_DONE = 1'b1;
        tick(1);
        INSN_DONE = 1'b0;
        wr(CPMC_PCTL_ADDR, 8'h02, 1'b1);
        chk(md, 4'h6);
        IRQ_PENDING = 1'b1;
        for (n = 0; md[1] !== 1'b0 && n < 12; n++) tick(1);
        chk({ser, md}, {last[7], last[6], last[4], last[3], 4'hC});
        if (n == 12) begin
            n_fail++;
            test_done();
        end
        IRQ_PENDING = 1'b0;
        tick(6);
        wr(CPMC_PCTL_ADDR, 8'h01, 1'b1);
        tick(2);
        RST = 1'b1;
        tick(1);
        RST = 1'b0;
        rd(CPMC_PCTL_ADDR);
        chk({v, md}, 12'h00C);
        // both bits: stop wins, irq ignored, no detector past its timeout
        wr(CPMC_PCTL_ADDR, 8'h03, 1'b1);
        IRQ_PENDING = 1'b1;
        tick(CPMC_DET_CYCLES + 50);
        chk({INTERNAL_RESET, md}, 5'h01);
        {IRQ_PENDING, RST} = 2'b01;
        tick(1);
        RST = 1'b0;
        chk({RESET_VECTOR, md}, 20'h0000C);
        // detector ends a stop that waited for the instruction end
        DETECTOR_ENABLE = 1'b1;
        wr(CPMC_PCTL_ADDR, 8'h02, 1'b0);
        tick(3);
        chk(md, 4'hC);
        INSN_DONE = 1'b1;
        tick(1);
        INSN_DONE = 1'b0;
        for (n = 1; INTERNAL_RESET !== 1'b1 && n < 5100; n++) tick(1);
        chk(n >= CPMC_DET_CYCLES - 4 && n <= CPMC_DET_CYCLES + 8, 1'b1);
        rd(CPMC_PCTL_ADDR);
        chk({v, md}, 12'h00C);
        test_done();
    end
endmodule : test_cpmc_top
